// >>> pxlg_map.svh
// constants of the pixel table and brightness correction stage
`ifndef PXLG_MAP_SVH
`define PXLG_MAP_SVH
`define PXLG_RAW_W 10
`define PXLG_OUT_W 8
`define PXLG_TABLE_DEPTH 1024
`define PXLG_BANK_DEPTH 256
`define PXLG_BANK_AW 8
`define PXLG_TOP_CODE 10'h3ff
`define PXLG_TABLE_LUMINANCE 1'b0
`define PXLG_GAMMA_W 12
`define PXLG_GAMMA_ONE 12'h400
`define PXLG_Y_MAX8 8'hff
`define PXLG_LOG_SPAN 14'h2000
`define PXLG_FIFO_DEPTH 16
`define PXLG_FIFO_LW 5
`define PXLG_READY_LEVEL 5'h0a
`define PXLG_RST_INDEX 10'h000
`define PXLG_RST_GAMMA 12'h400
`endif

// >>> pxlg_pkg.sv
// types shared by the pixel table and brightness correction stage
package pxlg_pkg;
  typedef struct packed {
    logic index_wr;     // table_entry_index write strobe
    logic [9:0] index;  // table_entry_index
    logic value_wr;     // table_entry_value write strobe
    logic [9:0] value;  // table_entry_value
    logic [0:0] select; // table_select
  } pxlg_tbl_wr_t;
  typedef struct packed {
    logic enable;       // correction on
    logic [11:0] gamma; // exponent, 2 integer and 10 fraction bits
  } pxlg_gamma_cfg_t;
endpackage

// >>> pxlg_store.sv
// storage modules: registered-read table bank and output fifo
`timescale 1ns/1ps
`default_nettype none
module pxlg_ram #(
  parameter int W = 10,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic mclk,            // clock
  input wire logic we,              // write enable
  input wire logic [AW-1:0] waddr,  // write address
  input wire logic [W-1:0] wdata,   // write data
  input wire logic [AW-1:0] raddr,  // read address
  output logic [W-1:0] rdata        // registered read data
);
  logic [W-1:0] mem [DEPTH];
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  // read-before-write on a collision: the old word comes out
  always_ff @(posedge mclk) begin
    rdata <= mem[raddr];
  end
endmodule // pxlg_ram

module pxlg_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic mclk,            // clock
  input wire logic nrst,            // sync reset, active low
  input wire logic in_valid,        // push request
  output logic in_ready,            // room in the array
  input wire logic [W-1:0] in_data, // pushed word
  output logic out_valid,           // output register holds a word
  input wire logic out_ready,       // consumer takes the word
  output logic [W-1:0] out_data,    // registered output word
  output logic [AW:0] level         // words held, array plus output register
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count != '0) && (!out_valid || out_ready);
  assign level = count + {{AW{1'b0}}, out_valid};
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
      case ({push, pop})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule // pxlg_fifo
`default_nettype wire

// >>> pxlg_top.sv
// pixel table mapping with interpolation, truncation and brightness correction
`timescale 1ns/1ps
`default_nettype none
`include "pxlg_map.svh"
// Function
// - 10-bit sample leaves as upper 8 bits
// - table off: output from raw sample
// - table on: mapped 10-bit value, then truncated
// - 1024 table entries, each 10 bits
// - even entries only; odd entries never used
// - odd samples interpolate between even neighbours
// - sample 1023 uses entry 1022 as is
// - only the luminance table is selectable
// - value write lands at selected index
// - mapping applies only while enabled
// - correction: max times normalized input powered
// - normalizing maximum 255 for 8-bit output; the code normalizes by 256 (log span 8 x 1024) instead
// - exponent one passes brightness unchanged
// - black and white never corrected
// - correction enable gates programmed exponent use
module pxlg_top import pxlg_pkg::*; (
  input wire logic mclk,                   // pixel clock, 125 MHz
  input wire logic nrst,                   // sync reset, active low
  input wire logic pix_in_valid,           // sensor sample present
  input wire logic [9:0] pix_in_data,      // 10-bit sensor sample
  output logic pix_in_ready,               // stage accepts a sample
  output logic pix_out_valid,              // output pixel present
  output logic [7:0] pix_out_data,         // 8-bit output pixel
  input wire logic pix_out_ready,          // consumer takes pixel
  input wire pxlg_tbl_wr_t tbl_wr,         // table loading strobes and data
  input wire logic table_map_enable,       // apply the table
  input wire pxlg_gamma_cfg_t gamma_cfg,   // correction enable and exponent
  output logic [9:0] table_index_now,      // currently selected index
  output logic write_rejected              // pulse: value write not stored
);
  // fixed point exponent must cover the top of the allowed range
  localparam int GAMMA_FRAC = 10;

  logic [9:0] next_index;
  logic sel_ok;
  logic wr_en;
  logic [`PXLG_BANK_AW-1:0] wr_addr;
  logic [9:0] wr_data;
  logic wr_bank;
  logic [`PXLG_BANK_AW-1:0] rd_addr0;
  logic [`PXLG_BANK_AW-1:0] rd_addr1;
  logic [9:0] bank0_q;
  logic [9:0] bank1_q;
  logic in_take;
  logic p1_valid;
  logic [9:0] p1_raw;
  logic [9:0] lo_entry;
  logic [9:0] hi_entry;
  logic [10:0] pair_sum;
  logic [9:0] next_mapped;
  logic p2_valid;
  logic [7:0] p2_pix;
  logic [9:0] p2_raw;
  logic p2_map_on;
  logic [9:0] p2_lo;
  logic [9:0] p2_hi;
  logic p3_valid;
  logic [7:0] p3_pix;
  logic [7:0] p3_in;
  logic p3_gon;
  logic [11:0] p3_gam;
  logic fifo_in_ready;
  logic [`PXLG_FIFO_LW-1:0] fifo_level;

  // power law through log2 and exp2, each mantissa bent by a parabola of 11/32;
  // a few codes off the exact curve, far cheaper than a full table per exponent
  function automatic logic [7:0] pxlg_gamma(input logic [7:0] x, input logic [11:0] g);
    logic [2:0] p;
    logic [14:0] sh;
    logic [6:0] f7;
    logic [17:0] bow;
    logic [9:0] f10;
    logic [13:0] n;
    logic [25:0] prod;
    logic [15:0] m;
    logic [12:0] k;
    logic [21:0] sag;
    logic [10:0] mant;
    logic [17:0] e;
    logic [7:0] y;
    p = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (x[i]) begin
        p = 3'(i);
      end
    end
    sh = {7'h00, x} << (3'h7 - p);
    f7 = sh[6:0];
    bow = 18'(f7) * (18'h00080 - 18'(f7));
    f10 = {f7, 3'h0} + 10'((bow * 18'h0000b) >> 9);
    n = `PXLG_LOG_SPAN - {1'b0, p, f10};
    prod = 26'(n) * 26'(g);
    m = prod[25:GAMMA_FRAC];
    k = 13'h0000;
    sag = 22'h000000;
    mant = 11'h000;
    e = 18'h00000;
    y = 8'h00;
    if (m == 16'h0000) begin
      // exponent zero or a pixel next to white: the exp step would reach 256
      y = `PXLG_Y_MAX8;
    end else if (m < 16'h2000) begin
      k = 13'(`PXLG_LOG_SPAN - 14'(m));
      sag = 22'(k[9:0]) * (22'h000400 - 22'(k[9:0]));
      mant = 11'h400 + 11'(k[9:0]) - 11'((sag * 22'h00000b) >> 15);
      e = 18'(mant) << k[12:10];
      y = e[17:10];
    end
    if (x == 8'h00) begin
      y = 8'h00;
    end else if (x == `PXLG_Y_MAX8) begin
      y = `PXLG_Y_MAX8;
    end else if (g == `PXLG_GAMMA_ONE) begin
      y = x;
    end
    return y;
  endfunction

  // table loading
  assign sel_ok = (tbl_wr.select == `PXLG_TABLE_LUMINANCE);
  assign next_index = tbl_wr.index_wr ? tbl_wr.index : table_index_now;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      table_index_now <= `PXLG_RST_INDEX;
    end else if (tbl_wr.index_wr && sel_ok) begin
      table_index_now <= tbl_wr.index;
    end
  end

  // odd entries are dropped on write, so they cannot reach the output
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wr_en <= 1'b0;
      wr_bank <= 1'b0;
      wr_addr <= '0;
      wr_data <= 10'h000;
      write_rejected <= 1'b0;
    end else begin
      wr_en <= tbl_wr.value_wr && sel_ok && !next_index[0];
      wr_bank <= next_index[1];
      wr_addr <= next_index[9:2];
      wr_data <= tbl_wr.value;
      write_rejected <= tbl_wr.value_wr && !(sel_ok && !next_index[0]);
    end
  end

  // entries 4k sit in bank 0, entries 4k+2 in bank 1: both neighbours read in one cycle
  assign rd_addr1 = pix_in_data[9:2];
  assign rd_addr0 = pix_in_data[1] ? (pix_in_data[9:2] + 8'h01) : pix_in_data[9:2];

  pxlg_ram #(.W(`PXLG_RAW_W), .DEPTH(`PXLG_BANK_DEPTH), .AW(`PXLG_BANK_AW)) u_bank0 (
    .mclk(mclk),
    .we(wr_en && !wr_bank),
    .waddr(wr_addr),
    .wdata(wr_data),
    .raddr(rd_addr0),
    .rdata(bank0_q)
  );

  pxlg_ram #(.W(`PXLG_RAW_W), .DEPTH(`PXLG_BANK_DEPTH), .AW(`PXLG_BANK_AW)) u_bank1 (
    .mclk(mclk),
    .we(wr_en && wr_bank),
    .waddr(wr_addr),
    .wdata(wr_data),
    .raddr(rd_addr1),
    .rdata(bank1_q)
  );

  // stage 1: table read
  assign in_take = pix_in_valid && pix_in_ready;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      p1_valid <= 1'b0;
      p1_raw <= 10'h000;
    end else begin
      p1_valid <= in_take;
      p1_raw <= pix_in_data;
    end
  end

  // stage 2: map, interpolate, truncate
  assign lo_entry = p1_raw[1] ? bank1_q : bank0_q;
  assign hi_entry = p1_raw[1] ? bank0_q : bank1_q;
  assign pair_sum = {1'b0, lo_entry} + {1'b0, hi_entry};

  always_comb begin
    next_mapped = p1_raw;
    if (table_map_enable) begin
      if (!p1_raw[0] || p1_raw == `PXLG_TOP_CODE) begin
        next_mapped = lo_entry;
      end else begin
        next_mapped = pair_sum[10:1];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      p2_valid <= 1'b0;
      p2_pix <= 8'h00;
      p2_raw <= 10'h000;
      p2_map_on <= 1'b0;
      p2_lo <= 10'h000;
      p2_hi <= 10'h000;
    end else begin
      p2_valid <= p1_valid;
      p2_pix <= next_mapped[9:2];
      p2_raw <= p1_raw;
      p2_map_on <= table_map_enable;
      p2_lo <= lo_entry;
      p2_hi <= hi_entry;
    end
  end

  // stage 3: brightness correction
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      p3_valid <= 1'b0;
      p3_pix <= 8'h00;
      p3_in <= 8'h00;
      p3_gon <= 1'b0;
      p3_gam <= `PXLG_RST_GAMMA;
    end else begin
      p3_valid <= p2_valid;
      p3_pix <= gamma_cfg.enable ? pxlg_gamma(p2_pix, gamma_cfg.gamma) : p2_pix;
      p3_in <= p2_pix;
      p3_gon <= gamma_cfg.enable;
      p3_gam <= gamma_cfg.gamma;
    end
  end

  // admission leaves room for the three samples in flight plus the one taken during the lag
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pix_in_ready <= 1'b0;
    end else begin
      pix_in_ready <= (fifo_level <= `PXLG_READY_LEVEL);
    end
  end

  pxlg_fifo #(.W(`PXLG_OUT_W), .DEPTH(`PXLG_FIFO_DEPTH), .AW(4)) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(p3_valid),
    .in_ready(fifo_in_ready),
    .in_data(p3_pix),
    .out_valid(pix_out_valid),
    .out_ready(pix_out_ready),
    .out_data(pix_out_data),
    .level(fifo_level)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  AST_BYPASS_TRUNC: assert property (p2_valid && !p2_map_on |-> p2_pix == p2_raw[9:2])
    else $error("bypass pixel is not the raw sample truncated");

  AST_EVEN_ENTRY: assert property (p2_valid && p2_map_on && !p2_raw[0] |-> p2_pix == p2_lo[9:2])
    else $error("even sample did not use its own entry");

  AST_INTERP: assert property (
    p2_valid && p2_map_on && p2_raw[0] && p2_raw != `PXLG_TOP_CODE
    |-> p2_pix == 8'((({1'b0, p2_lo} + {1'b0, p2_hi}) >> 1) >> 2))
    else $error("odd sample interpolation wrong");

  AST_TOP_CODE: assert property (p2_valid && p2_map_on && p2_raw == `PXLG_TOP_CODE |-> p2_pix == p2_lo[9:2])
    else $error("top code did not use entry 1022");

  AST_ENABLE_FOLLOWS: assert property (p1_valid && !table_map_enable |=> p2_pix == $past(p1_raw[9:2]))
    else $error("mapping enable not applied to the sample");

  AST_WRITE_AT_INDEX: assert property (
    tbl_wr.value_wr && sel_ok && !next_index[0]
    |=> wr_en && wr_addr == $past(next_index[9:2]) && wr_bank == $past(next_index[1]))
    else $error("table value not stored at selected index");

  AST_ODD_DROPPED: assert property (tbl_wr.value_wr && next_index[0] |=> !wr_en && write_rejected)
    else $error("odd table entry was stored");

  AST_SEL_ONLY_LUM: assert property (!sel_ok |=> !wr_en)
    else $error("write stored with no valid table selected");

  AST_GAMMA_OFF: assert property (p3_valid && !p3_gon |-> p3_pix == p3_in)
    else $error("correction applied while disabled");

  AST_GAMMA_UNITY: assert property (p3_valid && p3_gon && p3_gam == `PXLG_GAMMA_ONE |-> p3_pix == p3_in)
    else $error("unity exponent changed the pixel");

  AST_GAMMA_ENDS: assert property (
    p3_valid && p3_gon && (p3_in == 8'h00 || p3_in == `PXLG_Y_MAX8) |-> p3_pix == p3_in)
    else $error("black or white was corrected");

  AST_GAMMA_BRIGHTEN: assert property (
    p3_valid && p3_gon && p3_gam < 12'h200 && p3_in != 8'h00 |-> p3_pix >= p3_in)
    else $error("small exponent darkened the pixel");

  AST_LATENCY: assert property (in_take |-> ##3 p3_valid)
    else $error("sample did not reach the buffer in three cycles");

  AST_NO_OVERFLOW: assert property (p3_valid |-> fifo_in_ready)
    else $error("pixel pushed into a full buffer");

  COV_INTERP: cover property (p2_valid && p2_map_on && p2_raw[0] && p2_raw != `PXLG_TOP_CODE);
  COV_TOP: cover property (p2_valid && p2_map_on && p2_raw == `PXLG_TOP_CODE);
  COV_GAMMA: cover property (p3_valid && p3_gon && p3_pix != p3_in);
  COV_STALL: cover property (pix_in_valid && !pix_in_ready);
endmodule // pxlg_top
`default_nettype wire

// >>> pxlg_sensor_model.sv
// sensor sample source for the pixel stage
`timescale 1ns/1ps
`default_nettype none
module pxlg_sensor_model (
  input wire logic mclk,          // clock
  input wire logic nrst,          // sync reset, active low
  input wire logic start,         // begin a run
  input wire logic [9:0] first,   // first sample
  input wire logic [9:0] step,    // increment
  input wire logic [10:0] count,  // samples, at least one
  input wire logic slow,          // idle cycle between samples
  input wire logic pix_in_ready,  // stage takes
  output logic pix_in_valid,      // sample offered
  output logic [9:0] pix_in_data, // 10-bit sample
  output logic done               // run over
);
  logic [10:0] left;
  logic [9:0] next_sample;
  assign done = left == 11'h000;
  initial begin
    pix_in_valid = 1'b0;
    pix_in_data = 10'h155;
  end
  always @(posedge mclk) begin
    if (!nrst) begin
      pix_in_valid <= #1 1'b0;
      left <= #1 11'h000;
    end else if (start) begin
      pix_in_valid <= #1 1'b1;
      pix_in_data <= #1 first;
      left <= #1 count;
    end else if (pix_in_valid && pix_in_ready) begin
      left <= #1 left - 11'h001;
      next_sample <= #1 pix_in_data + step;
      pix_in_valid <= #1 !slow && left != 11'h001;
      pix_in_data <= #1 (slow || left == 11'h001) ? ~pix_in_data : pix_in_data + step;
    end else if (!pix_in_valid && !done) begin
      pix_in_valid <= #1 1'b1;
      pix_in_data <= #1 next_sample;
    end else if (!pix_in_valid)
      // idle line toggles so a stale sample never looks like a held one
      pix_in_data <= #1 ~pix_in_data;
  end
endmodule // pxlg_sensor_model
`default_nettype wire

// >>> tb_pixel_lut_gamma_corrector.sv
// self-checking bench for the pixel table and brightness correction stage
`timescale 1ns/1ps
`default_nettype none
module tb_pixel_lut_gamma_corrector import pxlg_pkg::*; ;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic pix_in_valid, pix_in_ready, pix_out_valid, write_rejected, done;
  logic pix_out_ready = 1'b0;
  logic [9:0] pix_in_data, table_index_now;
  logic [7:0] pix_out_data;
  pxlg_tbl_wr_t tbl_wr = '0;
  logic table_map_enable = 1'b0;
  pxlg_gamma_cfg_t gamma_cfg = '{enable: 1'b0, gamma: 12'h400};
  logic start = 1'b0, slow = 1'b0, stall = 1'b0, refused = 1'b0;
  logic [9:0] first = 10'h000, step = 10'h001;
  logic [10:0] count = 11'h001;
  logic [9:0] tbl [1024];
  logic [8:0] expq [$];
  int n_errors = 0, check_count = 0;
  always #4 mclk = ~mclk;
  pxlg_top DUT (.mclk(mclk), .nrst(nrst), .pix_in_valid(pix_in_valid), .pix_in_data(pix_in_data),
    .pix_in_ready(pix_in_ready), .pix_out_valid(pix_out_valid), .pix_out_data(pix_out_data),
    .pix_out_ready(pix_out_ready), .tbl_wr(tbl_wr), .table_map_enable(table_map_enable),
    .gamma_cfg(gamma_cfg), .table_index_now(table_index_now), .write_rejected(write_rejected));
  pxlg_sensor_model sensor (.mclk(mclk), .nrst(nrst), .start(start), .first(first), .step(step),
    .count(count), .slow(slow), .pix_in_ready(pix_in_ready), .pix_in_valid(pix_in_valid),
    .pix_in_data(pix_in_data), .done(done));
  task automatic report_and_stop();
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail(input string msg);
    n_errors++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask
  // bit 8 marks an approximated correction, compared with a margin
  function automatic logic [8:0] expect_pix(input logic [9:0] x);
    logic [10:0] m;
    logic [7:0] y;
    m = {1'b0, x};
    if (table_map_enable)
      m = !x[0] ? {1'b0, tbl[x]} : (x == 10'h3ff) ? {1'b0, tbl[1022]}
        : ({1'b0, tbl[x - 10'h001]} + {1'b0, tbl[x + 10'h001]}) >> 1;
    y = m[9:2];
    if (!gamma_cfg.enable || gamma_cfg.gamma == 12'h400 || y == 8'h00 || y == 8'hff)
      return {1'b0, y};
    return {1'b1, 8'($rtoi(255.0 * ((y / 255.0) ** (gamma_cfg.gamma / 1024.0)) + 0.5))};
  endfunction
  task automatic check_pix(input logic [7:0] got, input logic [8:0] e);
    check_count++;
    if (!e[8] ? got !== e[7:0] : ($isunknown(got) || got + 8 < e[7:0] || got > e[7:0] + 8))
      fail($sformatf("pixel %0h expected %0h", got, e[7:0]));
  endtask
  task automatic check_val(input logic [9:0] got, input logic [9:0] want);
    check_count++;
    if (got !== want)
      fail($sformatf("status %0h expected %0h", got, want));
  endtask
  always @(posedge mclk) begin
    if (nrst && pix_in_valid && pix_in_ready)
      expq.push_back(expect_pix(pix_in_data));
    if (nrst && pix_in_valid && !pix_in_ready)
      refused <= 1'b1;
    if (nrst && pix_out_valid && pix_out_ready) begin
      if (expq.size() == 0)
        fail("pixel without sample");
      else
        check_pix(pix_out_data, expq.pop_front());
    end
  end
  always @(posedge mclk)
    pix_out_ready <= #1 !stall && ($urandom % 4 != 0);
  task automatic host_op(input logic iw, input logic vw, input logic [9:0] v, input logic sel);
    @(posedge mclk) #1;
    tbl_wr = '{index_wr: iw, index: v, value_wr: vw, value: v, select: sel};
    @(posedge mclk) #1;
    tbl_wr = '0;
  endtask
  task automatic run(input logic [9:0] f, input logic [9:0] s, input int n, input logic sl, input logic st);
    int k;
    @(posedge mclk) #1;
    first = f;
    step = s;
    count = 11'(n);
    slow = sl;
    stall = st;
    start = 1'b1;
    @(posedge mclk) #1;
    start = 1'b0;
    // the model loads its count just after the start edge, so done is trustworthy only now
    @(posedge mclk) #1;
    for (k = 0; k < 4000 && (!done || expq.size() != 0 || stall); k++) begin
      @(posedge mclk) #1;
      if (k == 60)
        stall = 1'b0;
    end
    if (k == 4000) begin
      fail("stream timeout");
      report_and_stop();
    end
  endtask
  initial begin
    int i;
    logic [9:0] v;
    logic [11:0] gam [5];
    void'($urandom(32'hdb83));
    repeat (20) @(posedge mclk);
    #1;
    check_val({9'h000, pix_in_ready}, 10'h000);
    check_val({9'h000, pix_out_valid}, 10'h000);
    check_val(table_index_now, 10'h000);
    nrst = 1'b1;
    run(10'($urandom), 10'($urandom) | 10'h001, 40, 1'b0, 1'b0);
    for (i = 0; i < 1024; i += 2) begin
      v = (i % 4 == 0) ? 10'(1023 - i) : 10'($urandom);
      host_op(1'b1, 1'b0, 10'(i), 1'b0);
      check_val(table_index_now, 10'(i));
      host_op(1'b0, 1'b1, v, 1'b0);
      check_val({9'h000, write_rejected}, 10'h000);
      tbl[i] = v;
    end
    host_op(1'b1, 1'b0, 10'h011, 1'b0);
    host_op(1'b0, 1'b1, 10'h2aa, 1'b0);
    check_val({9'h000, write_rejected}, 10'h001);
    host_op(1'b1, 1'b0, 10'h004, 1'b1);
    check_val(table_index_now, 10'h011);
    host_op(1'b1, 1'b0, 10'h004, 1'b0);
    host_op(1'b0, 1'b1, 10'h155, 1'b1);
    check_val({9'h000, write_rejected}, 10'h001);
    host_op(1'b1, 1'b1, 10'h008, 1'b0);
    tbl[8] = 10'h008;
    table_map_enable = 1'b1;
    run(10'h3fc, 10'h001, 4, 1'b0, 1'b0);
    run(10'h000, 10'h001, 12, 1'b1, 1'b0);
    run(10'($urandom), 10'($urandom) | 10'h001, 120, 1'b0, 1'b1);
    check_val({9'h000, refused}, 10'h001);
    table_map_enable = 1'b0;
    // exponents stay inside the 2.10 range the host may program
    gam = '{12'h400, 12'h000, 12'hfff, 12'h200, 12'($urandom)};
    foreach (gam[j]) begin
      gamma_cfg = '{enable: 1'b1, gamma: gam[j]};
      run(10'h3f0, 10'h001, 32, 1'b0, 1'b0);
      run(10'($urandom), 10'h005, 64, 1'b0, 1'b0);
    end
    report_and_stop();
  end
endmodule // tb_pixel_lut_gamma_corrector
`default_nettype wire
